// file: rtl/tbl_pkg.sv
// Purpose: Shared constants for the program memory table access unit
// Assumes: One 250 MHz clock, instruction strobes from the core
// Notes:   Functional notes follow
package tbl_pkg;
  localparam int        ADDR_W       = 16;
  localparam int        WORD_W       = 16;
  localparam int        BYTE_W       = 8;
  localparam int        MEM_AW       = 8;
  // Register byte addresses
  localparam logic [3:0] OFS_PTR_LO  = 4'h0;
  localparam logic [3:0] OFS_PTR_HI  = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  localparam logic [3:0] OFS_LATCH   = 4'hc;
  // Status field positions
  localparam int        ST_LONG      = 0;
  localparam int        ST_EXT       = 1;
  localparam int        ST_VEC       = 2;
  localparam int        ST_ABORT     = 3;
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [15:0] LATCH_RST  = 16'h0000;
  // Interrupt source indices, 0 is highest priority
  localparam int        SRC_PIN      = 0;
  localparam int        SRC_T0OVF    = 1;
  localparam int        SRC_T0CKI    = 2;
  localparam int        SRC_PERIPH   = 3;
  localparam int        NSRC         = 4;
  typedef enum logic [2:0] {
    OP_NONE, OP_LATCH_LOAD, OP_LATCH_READ, OP_TABLE_WRITE, OP_TABLE_READ
  } op_t;
  typedef enum {ST_IDLE, ST_CYC2, ST_LONGW} fsm_t;
endpackage : tbl_pkg

// file: rtl/tbl_prio.sv
// Purpose: Highest priority one-hot pick among the fast clearable sources
// Assumes: Bit 0 has highest priority
// Notes:   Pure combinational
`timescale 1ns/1ns
`default_nettype none
module tbl_prio
  import tbl_pkg::*;
(
  // Request vector
  input  wire logic [2:0] req,
  // One-hot grant
  output logic      [2:0] gnt
);
  always_comb begin
    gnt = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (req[i]) begin
        gnt = 3'h0;
        gnt[i] = 1'b1;
      end
    end
  end
endmodule : tbl_prio
`default_nettype wire

// file: rtl/tbl_mem.sv
// Purpose: Small internal program memory model with registered read data
// Assumes: Word wide, one write port, one read port
// Notes:   Only low address bits index the array
`timescale 1ns/1ns
`default_nettype none
module tbl_mem
  import tbl_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Write port
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [WORD_W-1:0] wdata,
  // Read port
  input  wire logic              re,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem [2**MEM_AW];
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : tbl_mem
`default_nettype wire

// file: rtl/table_access.sv
// Purpose: Table read and write unit between byte data and word program memory
// Assumes: Core issues one op strobe when ready is high; ext read data sampled at the end of the cycle ext_re is high
// Notes:   Avalon slave exposes pointer and status; the latch stays unmapped
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module table_access
  import tbl_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Core instruction port
  input  wire logic              op_valid,
  input  wire op_t               op_code,
  input  wire logic              byte_sel,
  input  wire logic              incr,
  input  wire logic [BYTE_W-1:0] op_wdata,
  output logic      [BYTE_W-1:0] op_rdata,
  output logic                   op_rvalid,
  output logic                   op_ready,
  output logic                   core_halt,
  // Mode and interrupt context
  input  wire logic              ext_mode,
  input  wire logic              prog_voltage_ok,
  input  wire logic              global_interrupt_disable,
  input  wire logic [NSRC-1:0]   int_enable,
  input  wire logic [NSRC-1:0]   int_flag,
  output logic      [NSRC-1:0]   flag_clear,
  output logic                   periph_ack,
  output logic                   vector_req,
  // External program memory bus
  output logic      [ADDR_W-1:0] ext_addr,
  output logic      [WORD_W-1:0] ext_wdata,
  output logic                   ext_we,
  output logic                   ext_re,
  input  wire logic [WORD_W-1:0] ext_rdata,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);
  logic [ADDR_W-1:0] table_pointer_ff;
  logic [WORD_W-1:0] holding_latch_ff;
  fsm_t              state_ff;
  logic              is_read_ff;
  logic              incr_ff;
  logic              byte_sel_ff;
  logic              real_wr_ff;
  logic              ext_ff;
  logic              long_flag_ff;
  logic              abort_flag_ff;
  logic              vec_flag_ff;
  logic              ack_ff;
  logic [WORD_W-1:0] mem_rdata;
  logic [2:0]        fast_gnt;
  logic [NSRC-1:0]   active;
  logic              any_active;
  logic              take;
  logic              tw_int;
  logic              tw_abort;
  logic              long_end;
  logic              cyc2_done;
  logic [WORD_W-1:0] rd_word;
  logic              bus_wr;
  logic [ADDR_W-1:0] rd_addr;

  function automatic logic [BYTE_W-1:0] pick_byte(input logic [WORD_W-1:0] w, input logic hi);
    pick_byte = hi ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0];
  endfunction : pick_byte

  assign active     = int_enable & int_flag;
  assign any_active = |active;
  assign take       = op_valid && op_ready;
  assign tw_int     = take && op_code == OP_TABLE_WRITE && !ext_mode;
  assign tw_abort   = tw_int && any_active;
  assign long_end   = state_ff == ST_LONGW && any_active;
  assign cyc2_done  = state_ff == ST_CYC2;
  assign rd_word    = ext_ff ? ext_rdata : mem_rdata;
  assign op_ready   = state_ff == ST_IDLE;
  assign core_halt  = state_ff == ST_LONGW;
  assign bus_wr     = avs_write && state_ff == ST_IDLE && !op_valid;
  assign rd_addr    = nxt_rd_addr(table_pointer_ff, incr);

  function automatic logic [ADDR_W-1:0] nxt_rd_addr(input logic [ADDR_W-1:0] p, input logic inc);
    nxt_rd_addr = inc ? ADDR_W'(p + 16'h0001) : p;
  endfunction : nxt_rd_addr

  tbl_prio u_prio (
    .req (active[2:0]),
    .gnt (fast_gnt)
  );

  tbl_mem u_mem (
    .ref_clk (ref_clk),
    .we      (cyc2_done && !is_read_ff && !ext_ff && real_wr_ff),
    .waddr   (table_pointer_ff[MEM_AW-1:0]),
    .wdata   (holding_latch_ff),
    .re      (take && op_code == OP_TABLE_READ),
    .raddr   (rd_addr[MEM_AW-1:0]),
    .rdata   (mem_rdata)
  );

  // Sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      is_read_ff  <= 1'b0;
      incr_ff     <= 1'b0;
      byte_sel_ff <= 1'b0;
      real_wr_ff  <= 1'b0;
      ext_ff      <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take && (op_code == OP_TABLE_WRITE || op_code == OP_TABLE_READ)) begin
            is_read_ff  <= op_code == OP_TABLE_READ;
            incr_ff     <= incr;
            byte_sel_ff <= byte_sel;
            ext_ff      <= ext_mode;
            real_wr_ff  <= 1'b0;
            if (tw_int && !tw_abort && prog_voltage_ok) begin
              state_ff <= ST_LONGW;
            end else begin
              state_ff <= ST_CYC2;
            end
          end
        end
        ST_LONGW: begin
          if (long_end) begin
            real_wr_ff <= 1'b1;
            state_ff   <= ST_CYC2;
          end
        end
        ST_CYC2: begin
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Table pointer: bus write or post-access increment
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      table_pointer_ff <= PTR_RST;
    end else if (cyc2_done && incr_ff) begin
      table_pointer_ff <= ADDR_W'(table_pointer_ff + 16'h0001);
    end else if (bus_wr && avs_address == OFS_PTR_LO && avs_byteenable[0]) begin
      table_pointer_ff[7:0] <= avs_writedata[7:0];
    end else if (bus_wr && avs_address == OFS_PTR_HI && avs_byteenable[0]) begin
      table_pointer_ff[15:8] <= avs_writedata[7:0];
    end
  end

  // Holding latch: byte loads and read reloads
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      holding_latch_ff <= LATCH_RST;
    end else if (take && (op_code == OP_LATCH_LOAD || op_code == OP_TABLE_WRITE)) begin
      if (byte_sel) begin
        holding_latch_ff[15:8] <= op_wdata;
      end else begin
        holding_latch_ff[7:0] <= op_wdata;
      end
    end else if (cyc2_done && is_read_ff) begin
      holding_latch_ff <= rd_word;
    end
  end

  // Byte return to data memory, no memory access for latch read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_rdata  <= 8'h00;
      op_rvalid <= 1'b0;
    end else begin
      op_rvalid <= take && (op_code == OP_LATCH_READ || op_code == OP_TABLE_READ);
      if (take && (op_code == OP_LATCH_READ || op_code == OP_TABLE_READ)) begin
        op_rdata <= pick_byte(holding_latch_ff, byte_sel);
      end
    end
  end

  // External bus
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_addr  <= 16'h0000;
      ext_wdata <= 16'h0000;
      ext_we    <= 1'b0;
      ext_re    <= 1'b0;
    end else begin
      ext_we <= 1'b0;
      ext_re <= 1'b0;
      if (take && ext_mode && op_code == OP_TABLE_WRITE) begin
        ext_addr  <= table_pointer_ff;
        ext_wdata <= byte_sel ? {op_wdata, holding_latch_ff[7:0]} : {holding_latch_ff[15:8], op_wdata};
        ext_we    <= 1'b1;
      end else if (take && ext_mode && op_code == OP_TABLE_READ) begin
        ext_addr <= rd_addr;
        ext_re   <= 1'b1;
      end
    end
  end

  // Interrupt side effects
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_clear    <= '0;
      periph_ack    <= 1'b0;
      vector_req    <= 1'b0;
      long_flag_ff  <= 1'b0;
      abort_flag_ff <= 1'b0;
      vec_flag_ff   <= 1'b0;
      ack_ff        <= 1'b0;
    end else begin
      flag_clear <= '0;
      periph_ack <= 1'b0;
      vector_req <= 1'b0;
      long_flag_ff <= state_ff == ST_LONGW;
      if (tw_abort) begin
        flag_clear    <= {1'b0, fast_gnt};
        abort_flag_ff <= 1'b1;
        vector_req    <= !global_interrupt_disable;
      end else if (long_end) begin
        flag_clear  <= {1'b0, fast_gnt};
        vector_req  <= !global_interrupt_disable;
        vec_flag_ff <= !global_interrupt_disable;
      end else if (state_ff == ST_CYC2 && ext_ff && !is_read_ff && any_active) begin
        flag_clear <= {1'b0, fast_gnt};
        periph_ack <= ~|fast_gnt && active[SRC_PERIPH];
        ack_ff     <= 1'b1;
      end else if (take) begin
        abort_flag_ff <= 1'b0;
      end
    end
  end

  // Avalon slave, answers with waitrequest low in the request cycle when idle and op_valid is low
  assign avs_waitrequest = (avs_read || avs_write) && (state_ff != ST_IDLE || op_valid);
  always_comb begin
    case (avs_address)
      OFS_PTR_LO: avs_readdata = {24'h000000, table_pointer_ff[7:0]};
      OFS_PTR_HI: avs_readdata = {24'h000000, table_pointer_ff[15:8]};
      OFS_STATUS: avs_readdata = {28'h0000000, abort_flag_ff, vec_flag_ff, ext_mode, long_flag_ff};
      default:    avs_readdata = 32'h00000000;
    endcase
  end

  // Assertions
  property p_incr;
    @(posedge ref_clk) disable iff (!rstn)
      (state_ff == ST_CYC2 && incr_ff) |=> table_pointer_ff == ADDR_W'($past(table_pointer_ff) + 16'h0001);
  endproperty
  a_incr: assert property (p_incr) else $error("pointer not incremented");
  property p_noincr;
    @(posedge ref_clk) disable iff (!rstn)
      (state_ff == ST_CYC2 && !incr_ff && !bus_wr) |=> $stable(table_pointer_ff);
  endproperty
  a_noincr: assert property (p_noincr) else $error("pointer moved");
  property p_halt;
    @(posedge ref_clk) disable iff (!rstn)
      (tw_int && !tw_abort && prog_voltage_ok) |=> core_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("long write not started");
  property p_hold;
    @(posedge ref_clk) disable iff (!rstn)
      (core_halt && !any_active) |=> core_halt;
  endproperty
  a_hold: assert property (p_hold) else $error("long write ended early");
  property p_vec;
    @(posedge ref_clk) disable iff (!rstn)
      long_end |=> vector_req == !$past(global_interrupt_disable);
  endproperty
  a_vec: assert property (p_vec) else $error("vector decision wrong");
  property p_abort;
    @(posedge ref_clk) disable iff (!rstn)
      tw_abort |=> state_ff == ST_CYC2 ##1 state_ff == ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not a no-op");
  property p_ext2;
    @(posedge ref_clk) disable iff (!rstn)
      (take && ext_mode && op_code == OP_TABLE_WRITE) |=> ext_we && !op_ready ##1 op_ready;
  endproperty
  a_ext2: assert property (p_ext2) else $error("external write not two cycles");
  property p_periph;
    @(posedge ref_clk) disable iff (!rstn)
      long_end |=> !flag_clear[SRC_PERIPH];
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral flag cleared");
  property p_lread;
    @(posedge ref_clk) disable iff (!rstn)
      (take && op_code == OP_LATCH_READ) |=> $stable(table_pointer_ff) && !ext_re;
  endproperty
  a_lread: assert property (p_lread) else $error("latch read touched memory");
  c_long: cover property (@(posedge ref_clk) disable iff (!rstn) long_end);
  c_abort: cover property (@(posedge ref_clk) disable iff (!rstn) tw_abort);
  c_ext: cover property (@(posedge ref_clk) disable iff (!rstn) ext_we);
endmodule : table_access
`default_nettype wire

// file: tb/ext_pmem.sv
// Purpose: External program memory on the system bus
// Assumes: Write on ext_we, word shown while ext_re is high
// Notes:   Idle data bus shows the inverse of its last value
`timescale 1ns/1ns
`default_nettype none
module ext_pmem
  import tbl_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // System bus
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic [WORD_W-1:0] ext_wdata,
  input  wire logic              ext_we,
  input  wire logic              ext_re,
  output logic      [WORD_W-1:0] ext_rdata
);
  logic [WORD_W-1:0] mem [0:255];
  logic [WORD_W-1:0] idle_ff;
  initial begin
    idle_ff = 16'h5a5a;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // Store the word of the write cycle
  always @(posedge ref_clk) begin
    if (ext_we) begin
      mem[ext_addr[7:0]] <= ext_wdata;
    end
  end
  // Word stands while ext_re is high, the idle bus shows the inverse of its last value
  always @(posedge ref_clk) begin
    idle_ff <= ~ext_rdata;
  end
  assign ext_rdata = ext_re ? mem[ext_addr[7:0]] : idle_ff;
endmodule : ext_pmem
`default_nettype wire

// file: tb/table_access_tb.sv
// Purpose: Self-checking bench for the table access unit
// Assumes: External memory model on the system bus
// Notes:   Read bytes are checked by a monitor against a queue
`timescale 1ns/1ns
`default_nettype none
module table_access_tb
  import tbl_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        op_valid = 1'b0;
  op_t         op_code = OP_NONE;
  logic        byte_sel = 1'b0;
  logic        incr = 1'b0;
  logic [7:0]  op_wdata = 8'h00;
  logic        ext_mode = 1'b0;
  logic        prog_voltage_ok = 1'b0;
  logic        global_interrupt_disable = 1'b1;
  logic [3:0]  int_enable = 4'h0;
  logic [3:0]  int_flag = 4'h0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0]  op_rdata;
  logic        op_rvalid, op_ready, core_halt, periph_ack, vector_req, ext_we, ext_re, avs_waitrequest;
  logic [3:0]  flag_clear;
  logic [15:0] ext_addr, ext_wdata, ext_rdata;
  logic [31:0] avs_readdata;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          vec_n = 0;
  int          halt_n = 0;
  int          we_n = 0;
  int          h0;
  logic [3:0]  fc_seen = 4'h0;
  logic [31:0] seed = 32'hb50b;
  logic [15:0] w [0:3];
  logic [15:0] v;
  logic [8:0]  exp_q [$];
  logic [8:0]  ent;

  always #2 ref_clk = ~ref_clk;

  table_access u_dut (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .byte_sel(byte_sel), .incr(incr), .op_wdata(op_wdata), .op_rdata(op_rdata), .op_rvalid(op_rvalid),
    .op_ready(op_ready), .core_halt(core_halt), .ext_mode(ext_mode), .prog_voltage_ok(prog_voltage_ok),
    .global_interrupt_disable(global_interrupt_disable), .int_enable(int_enable), .int_flag(int_flag),
    .flag_clear(flag_clear), .periph_ack(periph_ack), .vector_req(vector_req), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_re(ext_re), .ext_rdata(ext_rdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  ext_pmem u_mem (.ref_clk(ref_clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_we(ext_we),
    .ext_re(ext_re), .ext_rdata(ext_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [31:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 500) miscompares++;
    if (!wr) chk(avs_readdata & m, e);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  task automatic op(input op_t c, input logic b, input logic i, input logic [7:0] d, input logic [8:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    byte_sel <= b;
    incr <= i;
    op_wdata <= d;
    @(posedge ref_clk);
    while (op_ready !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 500) miscompares++;
    if (c == OP_LATCH_READ || c == OP_TABLE_READ) exp_q.push_back(e);
    op_valid <= 1'b0;
  endtask : op

  // Word written as two byte operations
  task automatic tw(input logic [15:0] x, input logic i);
    op(OP_LATCH_LOAD, 1'b1, 1'b0, x[15:8], 9'h000);
    op(OP_TABLE_WRITE, 1'b0, i, x[7:0], 9'h000);
  endtask : tw

  // Dummy read fills the latch, then both halves are read
  task automatic rv(input logic [7:0] p, input logic [15:0] x);
    av(1'b1, OFS_PTR_LO, {24'h0, p}, 32'h0, 32'h0);
    op(OP_TABLE_READ, 1'b0, 1'b0, 8'h00, 9'h000);
    op(OP_LATCH_READ, 1'b1, 1'b0, 8'h00, {1'b1, x[15:8]});
    op(OP_LATCH_READ, 1'b0, 1'b0, 8'h00, {1'b1, x[7:0]});
  endtask : rv

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  always @(negedge ref_clk) begin
    if (op_rvalid === 1'b1) begin
      ent = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      if (ent[8]) chk(op_rdata, ent[7:0]);
    end
    fc_seen = fc_seen | flag_clear;
    if (vector_req === 1'b1) vec_n++;
    if (core_halt === 1'b1) halt_n++;
    if (ext_we === 1'b1) we_n++;
  end

  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    av(1'b0, OFS_PTR_LO, 32'h0, 32'hff, 32'h0);
    av(1'b0, OFS_PTR_HI, 32'h0, 32'hff, 32'h0);
    av(1'b1, OFS_LATCH, 32'h5a, 32'h0, 32'h0);
    av(1'b0, OFS_LATCH, 32'h0, 32'hffffffff, 32'h0);
    av(1'b0, OFS_STATUS, 32'h0, 32'h2, 32'h0);
    $display("Test reset values done");
    // External writes, first one with a pending pin interrupt
    ext_mode <= 1'b1;
    seed = xs(seed);
    av(1'b1, OFS_PTR_HI, {24'h0, seed[23:16]}, 32'h0, 32'h0);
    av(1'b1, OFS_PTR_LO, 32'h10, 32'h0, 32'h0);
    int_enable <= 4'b0001;
    int_flag <= 4'b0001;
    fc_seen = 4'h0;
    for (int k = 0; k < 4; k++) begin
      w[k] = 16'(xs(seed + k));
      tw(w[k], 1'b1);
      @(posedge ref_clk);
      int_flag <= 4'h0;
    end
    repeat (3) @(posedge ref_clk);
    chk(fc_seen, 4'b0001);
    chk(we_n, 4);
    for (int k = 0; k < 4; k++) chk(u_mem.mem[16 + k], w[k]);
    av(1'b0, OFS_PTR_LO, 32'h0, 32'hff, 32'h14);
    av(1'b0, OFS_PTR_HI, 32'h0, 32'hff, {24'h0, seed[23:16]});
    av(1'b0, OFS_STATUS, 32'h0, 32'h2, 32'h2);
    av(1'b1, OFS_PTR_LO, 32'h10, 32'h0, 32'h0);
    op(OP_TABLE_READ, 1'b0, 1'b0, 8'h00, 9'h000);
    for (int k = 0; k < 4; k++) begin
      op(OP_LATCH_READ, 1'b1, 1'b0, 8'h00, {1'b1, w[k][15:8]});
      op(OP_TABLE_READ, 1'b0, 1'b1, 8'h00, {1'b1, w[k][7:0]});
    end
    av(1'b0, OFS_PTR_LO, 32'h0, 32'hff, 32'h14);
    $display("Test external memory done");
    // Internal long write ended by timer-0 overflow, no vectoring
    ext_mode <= 1'b0;
    prog_voltage_ok <= 1'b1;
    int_enable <= 4'b0010;
    av(1'b1, OFS_PTR_LO, 32'h20, 32'h0, 32'h0);
    seed = xs(seed);
    v = seed[15:0];
    fc_seen = 4'h0;
    h0 = vec_n;
    halt_n = 0;
    tw(v, 1'b0);
    repeat (30) @(posedge ref_clk);
    chk(halt_n > 28, 1);
    int_flag <= 4'b0010;
    repeat (4) @(posedge ref_clk);
    int_flag <= 4'h0;
    chk(fc_seen, 4'b0010);
    chk(vec_n - h0, 0);
    rv(8'h20, v);
    $display("Test internal long write done");
    // Peripheral ends the write with vectoring
    global_interrupt_disable <= 1'b0;
    int_enable <= 4'b1000;
    av(1'b1, OFS_PTR_LO, 32'h21, 32'h0, 32'h0);
    fc_seen = 4'h0;
    tw(~v, 1'b0);
    repeat (10) @(posedge ref_clk);
    int_flag <= 4'b1000;
    repeat (4) @(posedge ref_clk);
    int_flag <= 4'h0;
    chk(fc_seen, 4'b0000);
    chk(vec_n - h0, 1);
    av(1'b0, OFS_STATUS, 32'h0, 32'h4, 32'h4);
    rv(8'h21, ~v);
    $display("Test peripheral termination done");
    // Pending pin and timer interrupts abort the write
    global_interrupt_disable <= 1'b1;
    int_enable <= 4'b0011;
    int_flag <= 4'b0011;
    av(1'b1, OFS_PTR_LO, 32'h20, 32'h0, 32'h0);
    fc_seen = 4'h0;
    halt_n = 0;
    tw(v ^ 16'h0ff0, 1'b0);
    repeat (4) @(posedge ref_clk);
    int_flag <= 4'h0;
    chk(fc_seen, 4'b0001);
    chk(halt_n, 0);
    av(1'b0, OFS_STATUS, 32'h0, 32'h8, 32'h8);
    rv(8'h20, v);
    $display("Test abort done");
    // No programming voltage: short write, memory unchanged
    prog_voltage_ok <= 1'b0;
    int_enable <= 4'h0;
    av(1'b1, OFS_PTR_LO, 32'h20, 32'h0, 32'h0);
    h0 = we_n;
    tw(16'h1234, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk(halt_n, 0);
    chk(we_n - h0, 0);
    rv(8'h20, v);
    $display("Test low voltage done");
    finish_test();
  end
endmodule : table_access_tb
`default_nettype wire
